// *** hw/rdrs_pkg.sv ***
// constants for the receive framer and decoder select block
// assumes one 250 MHz reference clock and an active-low asynchronous reset
// Summary of operation
// R1: with the decoder select low, each raw 10-bit framed character goes to the output unchanged.
// R2: the system keeps the clock source select at middle while the decoder is bypassed.
// R3: with the decoder select at middle, characters are decoded and specials use the native table.
// R4: with the decoder select high, characters are decoded and specials use the alternate table.
// R5: the reframe select chooses how boundaries move, together with the framing character kind.
// R6: with the reframe select low, every detected framing character realigns the boundary.
// R7: a low-latency realignment stretches the character clock so its edges meet the new data.
// R8: with the reframe select at middle, two framing characters on one alignment within 50 bits move it.
// R9: in multi-byte framing the character clock phase never changes when the boundary moves.
// R10: with the reframe select high, four adjacent framing characters on one alignment move it.
// R11: with the clock source select at middle, the clock output follows the recovered clock at the chosen rate.
// R12: reset clears all state and the outputs are settled within 16 reference cycles of release.
// R13: the system changes the decoder and reframe selects only while the block is held in reset.
package rdrs_pkg;
  localparam int BITS_PER_CHAR = 10;
  localparam int MB_SPAN_BITS = 50;
  localparam logic [3:0] LAST_BIT = 4'(BITS_PER_CHAR - 1);
  localparam logic [3:0] HALF_BIT = 4'(BITS_PER_CHAR / 2);
  localparam logic [3:0] STRETCH_BITS = 4'(BITS_PER_CHAR);
  localparam logic [5:0] MB_PAIR_MAX_AGE = 6'(MB_SPAN_BITS - BITS_PER_CHAR - 1);
  localparam logic [5:0] HB_ADJ_AGE = 6'(BITS_PER_CHAR - 1);
  localparam logic [5:0] AGE_MAX = 6'h3f;
  localparam logic [2:0] HB_LAST = 3'h3;
  localparam int RST_SETTLE_CYC = 16;
  localparam logic [4:0] SETTLE_LAST = 5'(RST_SETTLE_CYC - 1);
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_MID = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  localparam logic [6:0] COMMA_P = 7'h1f;
  localparam logic [6:0] COMMA_N = 7'h60;
  localparam logic [9:0] K285_N = 10'h0fa;
  localparam logic [9:0] K285_P = 10'h305;
  localparam logic [5:0] K28_N = 6'h0f;
  localparam logic [5:0] K28_P = 6'h30;
  localparam logic [7:0] K285_BYTE = 8'hbc;
  localparam int OUT_W = 12;
  localparam int FIFO_DEPTH = 8;
endpackage

// *** hw/rdrs_fifo.sv ***
// small show-ahead fifo with a registered read word
// assumes depth is a power of two and one clock domain
`timescale 1ns/1ps
module rdrs_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic ov;
    logic [WIDTH-1:0] od;
  } rdrs_fifo_s;
  rdrs_fifo_s st;
  rdrs_fifo_s n;
  logic full;
  logic empty;
  assign full = (st.wp[AW] != st.rp[AW]) && (st.wp[AW-1:0] == st.rp[AW-1:0]);
  assign empty = (st.wp == st.rp);
  assign o_ready = !full;
  assign o_valid = st.ov;
  assign o_data = st.od;
  always_comb
  begin
    n = st;
    if (i_valid && !full)
    begin
      n.mem[st.wp[AW-1:0]] = i_data;
      n.wp = st.wp + 1'b1;
    end
    if (!empty && (!st.ov || i_ready))
    begin
      n.od = st.mem[st.rp[AW-1:0]];
      n.ov = 1'b1;
      n.rp = st.rp + 1'b1;
    end
    else if (i_ready)
    begin
      n.ov = 1'b0;
    end
  end
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      st <= '0;
    else
      st <= n;
  end
  full_hold_a:
  assert property (@(posedge i_clk) disable iff (!i_nrst) full && i_valid |=> st.wp == $past(st.wp))
    else $error("fifo written while full");
endmodule

// *** hw/rdrs_top.sv ***
// receive character framer, decoder select and character clock for one channel
// assumes serial bits arrive one per strobe from the recovered clock side and get synchronised here
`timescale 1ns/1ps
module rdrs_top #(
  parameter int FIFO_DEPTH = rdrs_pkg::FIFO_DEPTH
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_rx_bit,
  input wire logic i_rx_bit_valid,
  input wire logic [1:0] i_decoder_select,
  input wire logic [1:0] i_reframe_select,
  input wire logic [1:0] i_rx_clock_source_select,
  input wire logic i_rx_clock_rate_select,
  input wire logic i_frame_char_select,
  input wire logic i_out_ready,
  output logic o_out_valid,
  output logic [rdrs_pkg::OUT_W-1:0] o_out_data,
  output logic o_rx_character_clock_out,
  output logic o_overflow,
  output logic o_rx_active
);
  typedef struct packed {
    logic bit_v;
    logic bit_d;
    logic [1:0] dec;
    logic [1:0] rf;
    logic [1:0] ck;
    logic rate;
    logic fsel;
  } rdrs_pins_s;
  typedef struct packed {
    rdrs_pins_s s1;
    rdrs_pins_s s2;
    logic [9:0] shreg;
    logic [3:0] bit_cnt;
    logic [3:0] ph_cnt;
    logic [3:0] stretch;
    logic [3:0] cand_off;
    logic [5:0] cand_age;
    logic [2:0] cand_num;
    logic [9:0] chr;
    logic chr_vld;
    logic clk;
    logic half;
    logic ovf;
    logic [4:0] settle;
    logic active;
  } rdrs_state_s;
  rdrs_state_s st;
  rdrs_state_s n;
  // 6b sub-block to 5 bits, error in the top bit
  function automatic logic [5:0] dec6(input logic [5:0] c);
    case (c)
      6'h27, 6'h18: dec6 = 6'h00;
      6'h1d, 6'h22: dec6 = 6'h01;
      6'h2d, 6'h12: dec6 = 6'h02;
      6'h31: dec6 = 6'h03;
      6'h35, 6'h0a: dec6 = 6'h04;
      6'h29: dec6 = 6'h05;
      6'h19: dec6 = 6'h06;
      6'h38, 6'h07: dec6 = 6'h07;
      6'h39, 6'h06: dec6 = 6'h08;
      6'h25: dec6 = 6'h09;
      6'h15: dec6 = 6'h0a;
      6'h34: dec6 = 6'h0b;
      6'h0d: dec6 = 6'h0c;
      6'h2c: dec6 = 6'h0d;
      6'h1c: dec6 = 6'h0e;
      6'h17, 6'h28: dec6 = 6'h0f;
      6'h1b, 6'h24: dec6 = 6'h10;
      6'h23: dec6 = 6'h11;
      6'h13: dec6 = 6'h12;
      6'h32: dec6 = 6'h13;
      6'h0b: dec6 = 6'h14;
      6'h2a: dec6 = 6'h15;
      6'h1a: dec6 = 6'h16;
      6'h3a, 6'h05: dec6 = 6'h17;
      6'h33, 6'h0c: dec6 = 6'h18;
      6'h26: dec6 = 6'h19;
      6'h16: dec6 = 6'h1a;
      6'h36, 6'h09: dec6 = 6'h1b;
      6'h0e, 6'h0f, 6'h30: dec6 = 6'h1c;
      6'h2e, 6'h11: dec6 = 6'h1d;
      6'h1e, 6'h21: dec6 = 6'h1e;
      6'h2b, 6'h14: dec6 = 6'h1f;
      default: dec6 = 6'h20;
    endcase
  endfunction
  // 4b sub-block to 3 bits, error in the top bit
  function automatic logic [3:0] dec4(input logic [3:0] c);
    case (c)
      4'hb, 4'h4: dec4 = 4'h0;
      4'h9: dec4 = 4'h1;
      4'h5: dec4 = 4'h2;
      4'hc, 4'h3: dec4 = 4'h3;
      4'hd, 4'h2: dec4 = 4'h4;
      4'ha: dec4 = 4'h5;
      4'h6: dec4 = 4'h6;
      4'he, 4'h1, 4'h7, 4'h8: dec4 = 4'h7;
      default: dec4 = 4'h8;
    endcase
  endfunction
  function automatic logic is_frame(input logic [9:0] w, input logic sel);
    if (sel)
      is_frame = (w == rdrs_pkg::K285_N) || (w == rdrs_pkg::K285_P);
    else
      is_frame = (w[9:3] == rdrs_pkg::COMMA_P) || (w[9:3] == rdrs_pkg::COMMA_N);
  endfunction
  // output word: special flag, code error, two zero bits, byte; raw mode carries 10 bits
  function automatic logic [11:0] decode_char(input logic [9:0] w, input logic [1:0] sel);
    logic [5:0] r6;
    logic [3:0] r4;
    logic k28;
    logic kx7;
    logic [7:0] b;
    r6 = dec6(w[9:4]);
    k28 = (w[9:4] == rdrs_pkg::K28_N) || (w[9:4] == rdrs_pkg::K28_P);
    r4 = dec4((w[9:4] == rdrs_pkg::K28_P) ? ~w[3:0] : w[3:0]);
    kx7 = ((w[3:0] == 4'h7) || (w[3:0] == 4'h8)) &&
          ((r6[4:0] == 5'h17) || (r6[4:0] == 5'h1b) || (r6[4:0] == 5'h1d) || (r6[4:0] == 5'h1e));
    b = {r4[2:0], r6[4:0]};
    if (sel == rdrs_pkg::LVL_LOW)
      decode_char = {2'h0, w}; // [R1]
    else if (sel == rdrs_pkg::LVL_HIGH && (k28 || kx7))
      decode_char = {1'b1, r6[5] | r4[3], 2'h0, b[2:0], b[7:3]}; // [R4]
    else
      decode_char = {k28 | kx7, r6[5] | r4[3], 2'h0, b}; // [R3]
  endfunction
  logic bv;
  logic [9:0] sh;
  logic hit;
  logic aligned;
  logic same;
  logic adj;
  logic recovered;
  logic fifo_ready;
  logic [11:0] push_data;
  assign bv = st.s2.bit_v;
  assign sh = {st.shreg[8:0], st.s2.bit_d};
  assign hit = is_frame(sh, st.s2.fsel);
  assign aligned = (st.bit_cnt == rdrs_pkg::LAST_BIT);
  assign same = (st.bit_cnt == st.cand_off);
  assign push_data = decode_char(st.chr, st.s2.dec);
  assign recovered = st.s2.rate ? st.half : (st.ph_cnt < rdrs_pkg::HALF_BIT);
  always_comb
  begin
    n = st;
    adj = 1'b0;
    n.s1 = {i_rx_bit_valid, i_rx_bit, i_decoder_select, i_reframe_select,
            i_rx_clock_source_select, i_rx_clock_rate_select, i_frame_char_select};
    n.s2 = st.s1;
    n.chr_vld = 1'b0;
    if (!st.active)
    begin
      n.settle = st.settle + 5'h1;
      n.active = (st.settle == rdrs_pkg::SETTLE_LAST); // [R12]
    end
    n.ovf = st.ovf | (st.chr_vld && st.active && !fifo_ready);
    if (bv)
    begin
      n.shreg = sh;
      n.cand_age = (st.cand_age == rdrs_pkg::AGE_MAX) ? rdrs_pkg::AGE_MAX : st.cand_age + 6'h1;
      n.bit_cnt = aligned ? 4'h0 : st.bit_cnt + 4'h1;
      n.chr_vld = aligned;
      n.chr = sh;
      case (st.s2.rf) // [R5]
        rdrs_pkg::LVL_LOW: adj = hit; // [R6]
        rdrs_pkg::LVL_MID:
        begin
          if (hit && st.cand_num != 3'h0 && same && st.cand_age <= rdrs_pkg::MB_PAIR_MAX_AGE)
          begin
            adj = 1'b1; // [R8]
            n.cand_num = 3'h0;
          end
          else if (hit)
          begin
            n.cand_num = 3'h1;
            n.cand_off = st.bit_cnt;
            n.cand_age = 6'h0;
          end
        end
        default:
        begin
          if (hit && st.cand_num != 3'h0 && same && st.cand_age == rdrs_pkg::HB_ADJ_AGE)
          begin
            n.cand_age = 6'h0;
            if (st.cand_num == rdrs_pkg::HB_LAST)
            begin
              adj = 1'b1; // [R10]
              n.cand_num = 3'h0;
            end
            else
              n.cand_num = st.cand_num + 3'h1;
          end
          else if (hit)
          begin
            n.cand_num = 3'h1;
            n.cand_off = st.bit_cnt;
            n.cand_age = 6'h0;
          end
        end
      endcase
      if (adj)
      begin
        n.bit_cnt = 4'h0;
        n.chr_vld = 1'b1;
      end
      if (st.stretch != 4'h0)
        n.stretch = st.stretch - 4'h1;
      if (st.s2.rf == rdrs_pkg::LVL_LOW)
      begin
        n.ph_cnt = n.bit_cnt;
        if (adj && !aligned)
          n.stretch = rdrs_pkg::STRETCH_BITS; // [R7]
      end
      else
        n.ph_cnt = (st.ph_cnt == rdrs_pkg::LAST_BIT) ? 4'h0 : st.ph_cnt + 4'h1; // [R9]
      if (n.ph_cnt == 4'h0)
        n.half = ~st.half;
    end
    if (st.s2.ck != rdrs_pkg::LVL_MID)
      n.clk = 1'b0;
    else if (st.stretch != 4'h0)
      n.clk = st.clk;
    else
      n.clk = recovered; // [R11]
  end
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      st <= '0; // [R12]
    else
      st <= n;
  end
  rdrs_fifo #(
    .WIDTH(rdrs_pkg::OUT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_valid(st.chr_vld && st.active),
    .o_ready(fifo_ready),
    .i_data(push_data),
    .o_valid(o_out_valid),
    .i_ready(i_out_ready),
    .o_data(o_out_data)
  );
  assign o_rx_character_clock_out = st.clk;
  assign o_overflow = st.ovf;
  assign o_rx_active = st.active;
  raw_pass_a: // [R1]
  assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    st.chr_vld && st.s2.dec == rdrs_pkg::LVL_LOW |-> push_data == {2'h0, st.chr})
    else $error("raw character altered");
  native_k_a: // [R3]
  assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    st.chr_vld && st.s2.dec == rdrs_pkg::LVL_MID && st.chr == rdrs_pkg::K285_N
    |-> push_data == {4'h8, rdrs_pkg::K285_BYTE})
    else $error("native special decode wrong");
  alt_k_a: // [R4]
  assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    st.chr_vld && st.s2.dec == rdrs_pkg::LVL_HIGH && st.chr == rdrs_pkg::K285_P
    |-> push_data == {4'h8, rdrs_pkg::K285_BYTE[2:0], rdrs_pkg::K285_BYTE[7:3]})
    else $error("alternate special decode wrong");
  ll_realign_a: // [R6]
  assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    bv && st.s2.rf == rdrs_pkg::LVL_LOW && hit |=> st.bit_cnt == 4'h0 && st.chr_vld && st.chr == $past(sh))
    else $error("low latency framer missed realign");
  ll_stretch_a: // [R7]
  assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    bv && st.s2.rf == rdrs_pkg::LVL_LOW && hit && !aligned
    |=> st.stretch == rdrs_pkg::STRETCH_BITS ##1 $stable(st.clk))
    else $error("character clock not stretched");
  mb_single_a: // [R8]
  assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    bv && st.s2.rf == rdrs_pkg::LVL_MID && hit && st.cand_num == 3'h0 && !aligned
    |=> st.cand_num == 3'h1 && st.bit_cnt == $past(st.bit_cnt) + 4'h1)
    else $error("multi-byte framer moved on one character");
  mb_phase_a: // [R9]
  assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    bv && st.s2.rf != rdrs_pkg::LVL_LOW
    |=> st.ph_cnt == (($past(st.ph_cnt) == rdrs_pkg::LAST_BIT) ? 4'h0 : $past(st.ph_cnt) + 4'h1))
    else $error("clock phase moved in multi-byte mode");
  hb_four_a: // [R10]
  assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    bv && st.s2.rf == rdrs_pkg::LVL_HIGH && hit && st.cand_num < rdrs_pkg::HB_LAST && !aligned
    |=> st.bit_cnt != 4'h0)
    else $error("alternate framer moved before four characters");
  clk_src_a: // [R11]
  assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    st.s2.ck != rdrs_pkg::LVL_MID |=> !o_rx_character_clock_out)
    else $error("clock output driven outside middle source select");
  settle_a: // [R12]
  assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    !st.active && st.settle == rdrs_pkg::SETTLE_LAST |=> st.active ##1 st.active && $stable(st.settle))
    else $error("block not active after settle count");
endmodule

// *** test/rdrs_tx_model.sv ***
// serial transmitter model: one bit per strobe, first bit of a character is bit a
// assumes the bench calls its tasks from one process and the bench clock
`timescale 1ns/1ps
module rdrs_tx_model (
  input wire logic i_clk,
  output logic o_bit,
  output logic o_bit_valid
);
  initial
  begin
    o_bit = 1'b0;
    o_bit_valid = 1'b0;
  end

  // sends the low n bits of c, msb first, back to back or with a gap cycle
  task automatic send(input logic [9:0] c, input int n, input logic slow);
    for (int i = n - 1; i >= 0; i--)
    begin
      @(posedge i_clk);
      #1;
      o_bit = c[i];
      o_bit_valid = 1'b1;
      if (slow)
      begin
        @(posedge i_clk);
        #1;
        o_bit = ~c[i];
        o_bit_valid = 1'b0;
      end
    end
  endtask

  // releases the line; data shows the inverse of the value the line last held
  task automatic idle();
    @(posedge i_clk);
    #1;
    o_bit = ~o_bit;
    o_bit_valid = 1'b0;
  endtask
endmodule

// *** test/rdrs_top_bench.sv ***
// self-checking bench for the receive framer and decoder select block
// assumes the serial model in rdrs_tx_model.sv and the design under hw/
`timescale 1ns/1ps
module rdrs_top_bench;
  logic i_ref_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [1:0] i_decoder_select = 2'h0;
  logic [1:0] i_reframe_select = 2'h0;
  logic [1:0] i_rx_clock_source_select = 2'h1;
  logic i_rx_clock_rate_select = 1'b0;
  logic i_frame_char_select = 1'b0;
  logic i_out_ready = 1'b1;
  logic rx_bit;
  logic rx_bit_valid;
  logic o_out_valid;
  logic [rdrs_pkg::OUT_W-1:0] o_out_data;
  logic clk_out;
  logic o_overflow;
  logic o_rx_active;
  logic [11:0] got[$];
  logic [9:0] seq[$];
  int clk_high;
  int fail_count;
  int comparisons;
  int hits;

  always #2 i_ref_clk = ~i_ref_clk;

  rdrs_tx_model u_rdrs_tx_model (
    .i_clk(i_ref_clk),
    .o_bit(rx_bit),
    .o_bit_valid(rx_bit_valid)
  );

  rdrs_top #(
    .FIFO_DEPTH(rdrs_pkg::FIFO_DEPTH)
  ) u_rdrs_top (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_rx_bit(rx_bit),
    .i_rx_bit_valid(rx_bit_valid),
    .i_decoder_select(i_decoder_select),
    .i_reframe_select(i_reframe_select),
    .i_rx_clock_source_select(i_rx_clock_source_select),
    .i_rx_clock_rate_select(i_rx_clock_rate_select),
    .i_frame_char_select(i_frame_char_select),
    .i_out_ready(i_out_ready),
    .o_out_valid(o_out_valid),
    .o_out_data(o_out_data),
    .o_rx_character_clock_out(clk_out),
    .o_overflow(o_overflow),
    .o_rx_active(o_rx_active)
  );

  // collects accepted words and counts high clock-out cycles
  always @(posedge i_ref_clk)
  begin
    if (o_out_valid === 1'b1 && i_out_ready === 1'b1)
      got.push_back(o_out_data);
    if (clk_out === 1'b1)
      clk_high++;
  end

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  function automatic logic [11:0] expect_word(input logic [1:0] dec, input logic [9:0] c);
    if (dec == rdrs_pkg::LVL_LOW)
      return {2'h0, c};
    if (c == rdrs_pkg::K285_N || c == rdrs_pkg::K285_P)
      return (dec == rdrs_pkg::LVL_HIGH) ? 12'h897 : {4'h8, rdrs_pkg::K285_BYTE};
    return 12'h0b5;
  endfunction

  // selects change only inside reset; settle time checked after release
  task automatic do_reset(input logic [1:0] dec, input logic [1:0] rf, input logic [1:0] src, input logic alt);
    @(posedge i_ref_clk);
    #1;
    i_nrst = 1'b0;
    i_decoder_select = dec;
    i_reframe_select = rf;
    i_rx_clock_source_select = src;
    i_frame_char_select = alt;
    i_rx_clock_rate_select = alt;
    repeat (10) @(posedge i_ref_clk);
    #1;
    check({9'h0, o_out_valid, o_overflow, o_rx_active}, 12'h000);
    i_nrst = 1'b1;
    repeat (15) @(posedge i_ref_clk);
    #1;
    check({11'h0, o_rx_active}, 12'h000);
    @(posedge i_ref_clk);
    #1;
    check({11'h0, o_rx_active}, 12'h001);
    got.delete();
    clk_high = 0;
  endtask

  // three-bit offset first so the framer has to move the boundary
  task automatic send_seq(input logic slow);
    u_rdrs_tx_model.send(10'h005, 3, slow);
    foreach (seq[i])
      u_rdrs_tx_model.send(seq[i], 10, slow);
    u_rdrs_tx_model.idle();
    repeat (30) @(posedge i_ref_clk);
    #1;
  endtask

  task automatic run_mode(input logic [1:0] dec, input logic [1:0] rf, input logic [1:0] src, input logic slow,
                          input int commas);
    do_reset(dec, rf, src, slow);
    seq = '{10'h0fa, 10'h305, 10'h0fa, 10'h305, 10'h2aa, 10'h0fa, 10'h2aa};
    send_seq(slow);
    hits = 0;
    foreach (got[i])
      if (got[i] === expect_word(dec, 10'h0fa) || got[i] === expect_word(dec, 10'h305))
        hits++;
    check(12'(hits), 12'(commas));
    check(got[$-2], expect_word(dec, 10'h2aa));
    check(got[$-1], expect_word(dec, 10'h0fa));
    check(got[$], expect_word(dec, 10'h2aa));
    check({11'h0, clk_high != 0}, {11'h0, src == rdrs_pkg::LVL_MID});
  endtask

  initial
  begin
    run_mode(2'h0, 2'h0, 2'h1, 1'b0, 5);
    run_mode(2'h1, 2'h1, 2'h1, 1'b1, 4);
    run_mode(2'h2, 2'h2, 2'h0, 1'b0, 2);
    // fifo filled with the consumer stalled, then drained
    do_reset(2'h1, 2'h0, 2'h1, 1'b0);
    i_out_ready = 1'b0;
    seq = '{10'h0fa, 10'h2aa, 10'h305, 10'h2aa, 10'h0fa, 10'h2aa, 10'h305, 10'h2aa,
            10'h0fa, 10'h2aa, 10'h305, 10'h2aa};
    send_seq(1'b0);
    check({11'h0, o_overflow}, 12'h001);
    i_out_ready = 1'b1;
    repeat (20) @(posedge i_ref_clk);
    #1;
    check(12'(got.size()), 12'(rdrs_pkg::FIFO_DEPTH + 1)); // registered read word holds one beyond memory
    check({11'h0, o_overflow}, 12'h001);
    complete_run();
  end

  // watchdog well beyond the several hundred cycles the tests need
  initial
  begin
    #100000;
    fail_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule
